// file: dmc_pkg.sv
// Package with register map, field layout and reset values of the two-channel transfer controller.
package dmc_pkg;
   localparam int NUM_CH = 2;
   localparam int SEL_W = 3;
   localparam int NUM_REQ = 8;

   // Register offsets on the plain register port.
   localparam logic [4:0] CH_STRIDE = 5'h08;
   localparam logic [2:0] OFF_CTRL = 3'h0;
   localparam logic [2:0] OFF_SRC_RL = 3'h1;
   localparam logic [2:0] OFF_DST_RL = 3'h2;
   localparam logic [2:0] OFF_CNT_RL = 3'h3;
   localparam logic [2:0] OFF_FWD_PTR = 3'h4;
   localparam logic [2:0] OFF_COUNT = 3'h5;
   localparam logic [4:0] IRQ_STATUS = 5'h10;
   localparam logic [4:0] IRQ_CLEAR = 5'h11;
   localparam logic [4:0] IRQ_ENABLE = 5'h12;

   // Control register field positions.
   localparam int CTRL_FWD_BIT = 0;
   localparam int CTRL_EN_BIT = 3;
   localparam int CTRL_FLAG_BIT = 4;
   localparam int CTRL_SEL_LSB = 5;

   // Values after reset, and the count value that marks the last transfer.
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [1:0] IRQ_RST = 2'h0;
   localparam logic [15:0] COUNT_LAST = 16'h0001;

   typedef logic [15:0] dmc_word_t;

   // Control register layout, bit 7 down to bit 0.
   typedef struct packed {
      logic [SEL_W-1:0] sel;
      logic flag;
      logic enable;
      logic [1:0] rsvd;
      logic fwd_dst;
   } dmc_ctrl_s;

   localparam dmc_ctrl_s CTRL_RST = '{sel: 3'h0, flag: 1'b0, enable: 1'b0, rsvd: 2'h0,
                                      fwd_dst: 1'b0};
endpackage : dmc_pkg

// file: dmc_chan_if.sv
// Interface between the controller top and one transfer channel.
`timescale 1ns/10ps
interface dmc_chan_if;
   import dmc_pkg::*;
   logic wr_ctrl;
   logic wr_src_rl;
   logic wr_dst_rl;
   logic wr_cnt_rl;
   dmc_word_t wdata;
   logic [NUM_REQ-1:0] req_lines;
   logic grant;
   dmc_ctrl_s ctrl;
   dmc_word_t src_rl;
   dmc_word_t dst_rl;
   dmc_word_t cnt_rl;
   dmc_word_t fwd_ptr;
   dmc_word_t count;
   dmc_word_t src_addr;
   dmc_word_t dst_addr;
   logic want;
   logic done;

   modport top (output wr_ctrl, output wr_src_rl, output wr_dst_rl, output wr_cnt_rl,
                output wdata, output req_lines, output grant, input ctrl, input src_rl,
                input dst_rl, input cnt_rl, input fwd_ptr, input count, input src_addr,
                input dst_addr, input want, input done);
   modport chan (input wr_ctrl, input wr_src_rl, input wr_dst_rl, input wr_cnt_rl,
                 input wdata, input req_lines, input grant, output ctrl, output src_rl,
                 output dst_rl, output cnt_rl, output fwd_ptr, output count, output src_addr,
                 output dst_addr, output want, output done);
endinterface : dmc_chan_if

// file: dmc_channel.sv
// One transfer channel: enable, reloads, request flag and pointer stepping.
`timescale 1ns/10ps
module dmc_channel
   import dmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   dmc_chan_if.chan cif
);
   typedef struct packed {
      dmc_ctrl_s ctrl;
      logic req_prev;
      dmc_word_t src_rl;
      dmc_word_t dst_rl;
      dmc_word_t cnt_rl;
      dmc_word_t fwd_ptr;
      dmc_word_t count;
   } dmc_chan_s;

   dmc_chan_s s_reg;
   dmc_chan_s s_next;
   dmc_ctrl_s wctrl;
   logic sel_now;
   logic req_edge;
   logic xfer;

   assign wctrl = dmc_ctrl_s'(cif.wdata[7:0]);
   // The previous level is of the line selected a cycle earlier, so a new selection can fake an edge.
   assign sel_now = cif.req_lines[s_reg.ctrl.sel];
   assign req_edge = sel_now & ~s_reg.req_prev;
   assign xfer = cif.grant & cif.want;

   // Next state: transfer first, then software writes, then request set, which wins any clear.
   always_comb begin
      s_next = s_reg;
      s_next.req_prev = sel_now;
      if (xfer) begin
         s_next.ctrl.flag = 1'b0;
         s_next.fwd_ptr = s_reg.fwd_ptr + 16'h0001;
         s_next.count = s_reg.count - 16'h0001;
         if (s_reg.count == COUNT_LAST) begin
            s_next.ctrl.enable = 1'b0;
         end
      end
      if (cif.wr_ctrl) begin
         s_next.ctrl.sel = wctrl.sel;
         s_next.ctrl.fwd_dst = wctrl.fwd_dst;
         if (!wctrl.enable) begin
            s_next.ctrl.enable = 1'b0;
         end else if (!s_reg.ctrl.enable) begin
            // Activation from idle restarts from scratch; writing one while the bit already reads one reloads nothing.
            s_next.ctrl.enable = 1'b1;
            s_next.fwd_ptr = wctrl.fwd_dst ? s_reg.dst_rl : s_reg.src_rl;
            s_next.count = s_reg.cnt_rl;
         end
         if (!wctrl.flag) begin
            s_next.ctrl.flag = 1'b0;
         end
      end
      if (cif.wr_src_rl) begin
         s_next.src_rl = cif.wdata;
      end
      if (cif.wr_dst_rl) begin
         s_next.dst_rl = cif.wdata;
      end
      if (cif.wr_cnt_rl) begin
         s_next.cnt_rl = cif.wdata;
      end
      // The flag is set whatever the enable says and stays until served or cleared.
      if (req_edge) begin
         s_next.ctrl.flag = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{ctrl: CTRL_RST, req_prev: 1'b0, src_rl: WORD_RST, dst_rl: WORD_RST,
                    cnt_rl: WORD_RST, fwd_ptr: WORD_RST, count: WORD_RST};
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs towards the top; the fixed pointer is taken straight from its reload value.
   assign cif.ctrl = s_reg.ctrl;
   assign cif.src_rl = s_reg.src_rl;
   assign cif.dst_rl = s_reg.dst_rl;
   assign cif.cnt_rl = s_reg.cnt_rl;
   assign cif.fwd_ptr = s_reg.fwd_ptr;
   assign cif.count = s_reg.count;
   assign cif.src_addr = s_reg.ctrl.fwd_dst ? s_reg.src_rl : s_reg.fwd_ptr;
   assign cif.dst_addr = s_reg.ctrl.fwd_dst ? s_reg.fwd_ptr : s_reg.dst_rl;
   assign cif.want = s_reg.ctrl.enable & s_reg.ctrl.flag;
   assign cif.done = xfer & (s_reg.count == COUNT_LAST);

   a_flag_set_edge: assert property (@(posedge clk) disable iff (!rst_n)
      req_edge |=> s_reg.ctrl.flag) else $error("request edge did not set flag");
   a_flag_clr_xfer: assert property (@(posedge clk) disable iff (!rst_n)
      xfer && !req_edge |=> !s_reg.ctrl.flag) else $error("flag kept after transfer");
   a_sw_one_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      cif.wr_ctrl && wctrl.flag && !s_reg.ctrl.flag && !req_edge |=> !s_reg.ctrl.flag)
      else $error("software set the request flag");
   a_enable_count_rl: assert property (@(posedge clk) disable iff (!rst_n)
      cif.wr_ctrl && wctrl.enable && !s_reg.ctrl.enable
      |=> s_reg.ctrl.enable && s_reg.count == $past(s_reg.cnt_rl))
      else $error("activation missed counter reload");
   a_enable_ptr_rl: assert property (@(posedge clk) disable iff (!rst_n)
      cif.wr_ctrl && wctrl.enable && !wctrl.fwd_dst && !s_reg.ctrl.enable
      |=> s_reg.fwd_ptr == $past(s_reg.src_rl)) else $error("pointer not reloaded");
   a_pending_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !s_reg.ctrl.enable && s_reg.ctrl.flag && !cif.wr_ctrl |=> s_reg.ctrl.flag)
      else $error("pending request lost");
endmodule : dmc_channel

// file: dmc_top.sv
// Top of the two-channel transfer controller: register port, arbitration, interrupt.
// Register map, word per index: channel n at n*8 (control, source reload, destination
// reload, count reload, forward pointer, count), then interrupt status, clear and enable.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module dmc_top
   import dmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic [NUM_REQ-1:0] req_lines,
   output logic xfer_valid,
   output logic xfer_chan,
   output logic [15:0] xfer_src,
   output logic [15:0] xfer_dst,
   output logic irq
);
   typedef struct packed {
      dmc_word_t rdata;
      logic [NUM_CH-1:0] status;
      logic [NUM_CH-1:0] irq_en;
      logic irq;
      logic xv;
      logic xch;
      dmc_word_t xsrc;
      dmc_word_t xdst;
   } dmc_top_s;

   dmc_top_s s_reg;
   dmc_top_s s_next;
   dmc_ctrl_s ch_ctrl [NUM_CH];
   dmc_word_t ch_src_rl [NUM_CH];
   dmc_word_t ch_dst_rl [NUM_CH];
   dmc_word_t ch_cnt_rl [NUM_CH];
   dmc_word_t ch_fwd [NUM_CH];
   dmc_word_t ch_count [NUM_CH];
   dmc_word_t ch_src_addr [NUM_CH];
   dmc_word_t ch_dst_addr [NUM_CH];
   logic [NUM_CH-1:0] ch_want;
   logic [NUM_CH-1:0] ch_grant;
   logic [NUM_CH-1:0] ch_done;

   dmc_chan_if cif [NUM_CH] ();

   // Channel 0 has fixed priority; a lower channel's request holds the other off one cycle.
   assign ch_grant[0] = ch_want[0];
   assign ch_grant[1] = ch_want[1] & ~ch_want[0];

   // Per-channel write strobes and readback wiring.
   for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch
      localparam logic [4:0] BASE = CH_STRIDE * 5'(g);
      assign cif[g].wr_ctrl = wr && (addr == (BASE | {2'b00, OFF_CTRL}));
      assign cif[g].wr_src_rl = wr && (addr == (BASE | {2'b00, OFF_SRC_RL}));
      assign cif[g].wr_dst_rl = wr && (addr == (BASE | {2'b00, OFF_DST_RL}));
      assign cif[g].wr_cnt_rl = wr && (addr == (BASE | {2'b00, OFF_CNT_RL}));
      assign cif[g].wdata = wdata;
      assign cif[g].req_lines = req_lines;
      assign cif[g].grant = ch_grant[g];
      assign ch_ctrl[g] = cif[g].ctrl;
      assign ch_src_rl[g] = cif[g].src_rl;
      assign ch_dst_rl[g] = cif[g].dst_rl;
      assign ch_cnt_rl[g] = cif[g].cnt_rl;
      assign ch_fwd[g] = cif[g].fwd_ptr;
      assign ch_count[g] = cif[g].count;
      assign ch_src_addr[g] = cif[g].src_addr;
      assign ch_dst_addr[g] = cif[g].dst_addr;
      assign ch_want[g] = cif[g].want;
      assign ch_done[g] = cif[g].done;

      dmc_channel u_chan (
         .clk(clk),
         .rst_n(rst_n),
         .cif(cif[g])
      );
   end

   // Next state of the register port, interrupt logic and transfer output.
   always_comb begin
      logic chs;
      logic [2:0] off;
      chs = addr[3];
      off = addr[2:0];
      s_next = s_reg;
      s_next.rdata = WORD_RST;
      s_next.xv = 1'b0;
      // Reads answer one cycle later; unmapped and write-only addresses read zero.
      if (rd) begin
         if (addr[4]) begin
            if (addr == IRQ_STATUS) begin
               s_next.rdata = {14'h0000, s_reg.status};
            end else if (addr == IRQ_ENABLE) begin
               s_next.rdata = {14'h0000, s_reg.irq_en};
            end
         end else if (off == OFF_CTRL) begin
            // The enable bit shows whether the channel is active.
            s_next.rdata = {8'h00, ch_ctrl[chs]};
         end else if (off == OFF_SRC_RL) begin
            s_next.rdata = ch_src_rl[chs];
         end else if (off == OFF_DST_RL) begin
            s_next.rdata = ch_dst_rl[chs];
         end else if (off == OFF_CNT_RL) begin
            s_next.rdata = ch_cnt_rl[chs];
         end else if (off == OFF_FWD_PTR) begin
            s_next.rdata = ch_fwd[chs];
         end else if (off == OFF_COUNT) begin
            s_next.rdata = ch_count[chs];
         end
      end
      // Clearing happens before setting, so a completion in the clearing cycle is kept.
      if (wr && addr == IRQ_CLEAR) begin
         s_next.status = s_reg.status & ~wdata[NUM_CH-1:0];
      end
      s_next.status = s_next.status | ch_done;
      if (wr && addr == IRQ_ENABLE) begin
         s_next.irq_en = wdata[NUM_CH-1:0];
      end
      s_next.irq = |(s_next.status & s_next.irq_en);
      // A granted channel presents its transfer in the following cycle.
      if (ch_grant[0]) begin
         s_next.xv = 1'b1;
         s_next.xch = 1'b0;
         s_next.xsrc = ch_src_addr[0];
         s_next.xdst = ch_dst_addr[0];
      end else if (ch_grant[1]) begin
         s_next.xv = 1'b1;
         s_next.xch = 1'b1;
         s_next.xsrc = ch_src_addr[1];
         s_next.xdst = ch_dst_addr[1];
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{rdata: WORD_RST, status: IRQ_RST, irq_en: IRQ_RST, irq: 1'b0, xv: 1'b0,
                    xch: 1'b0, xsrc: WORD_RST, xdst: WORD_RST};
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata = s_reg.rdata;
   assign xfer_valid = s_reg.xv;
   assign xfer_chan = s_reg.xch;
   assign xfer_src = s_reg.xsrc;
   assign xfer_dst = s_reg.xdst;
   assign irq = s_reg.irq;

   a_active_served: assert property (@(posedge clk) disable iff (!rst_n)
      ch_want[0] |=> xfer_valid && !xfer_chan) else $error("active request not served");
   a_ctrl_read_enable: assert property (@(posedge clk) disable iff (!rst_n)
      rd && addr == {2'b00, OFF_CTRL} |=> rdata[CTRL_EN_BIT] == $past(ch_ctrl[0].enable))
      else $error("enable readback wrong");
   // A clear written right after the completion may drop the line again, so only one cycle is held.
   a_irq_done: assert property (@(posedge clk) disable iff (!rst_n)
      |(ch_done & s_reg.irq_en) && !(wr && addr == IRQ_ENABLE) |=> irq)
      else $error("completion interrupt missing");
endmodule : dmc_top

// file: dmc_req_model.sv
// Model of the peripherals that raise the shared transfer request lines.
`timescale 1ns/10ps
module dmc_req_model
   import dmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fire,
   input wire logic [SEL_W-1:0] line,
   input wire logic hold,
   output logic [NUM_REQ-1:0] req_lines
);
   logic [1:0] life_reg;

   // A request is a rising edge kept high three cycles, or longer while hold is up.
   // Only one line is high at a time, so a pulse never hides an edge on another line.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_lines <= '0;
         life_reg <= 2'h0;
      end else if (fire) begin
         req_lines <= NUM_REQ'(1) << line;
         life_reg <= 2'h2;
      end else if (life_reg != 2'h0) begin
         life_reg <= life_reg - 2'h1;
      end else if (!hold) begin
         req_lines <= '0;
      end
   end
endmodule : dmc_req_model

// file: tb_top.sv
// Self-checking testbench of the two-channel transfer controller.
`timescale 1ns/10ps
module tb_top
   import dmc_pkg::*;
;
   logic clk;
   logic rst_n;
   logic [4:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic [15:0] rdata;
   logic [NUM_REQ-1:0] req_lines;
   logic xfer_valid;
   logic xfer_chan;
   logic [15:0] xfer_src;
   logic [15:0] xfer_dst;
   logic irq;
   logic fire;
   logic [SEL_W-1:0] line;
   logic hold;
   int n_errors;
   int checked;

   dmc_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                .rdata(rdata), .req_lines(req_lines), .xfer_valid(xfer_valid),
                .xfer_chan(xfer_chan), .xfer_src(xfer_src), .xfer_dst(xfer_dst), .irq(irq));

   dmc_req_model periph (.clk(clk), .rst_n(rst_n), .fire(fire), .line(line), .hold(hold),
                         .req_lines(req_lines));

   // Free-running 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Prints the verdict and ends the run.
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   // Compares one observed value with its expectation.
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Register index of a channel register.
   function automatic logic [4:0] ra(input logic ch, input logic [2:0] off);
      return {1'b0, ch, off};
   endfunction : ra

   // One-cycle write strobe.
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // One-cycle read strobe; the data stand only in the following cycle.
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", rdata, exp);
   endtask : rd_chk

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   // Asks the peripheral model for a request edge on one line.
   task automatic req(input logic [SEL_W-1:0] l, input logic h);
      @(posedge clk);
      fire <= 1'b1;
      line <= l;
      hold <= h;
      @(posedge clk);
      fire <= 1'b0;
   endtask : req

   // Waits a bounded time for one transfer and checks what it carried.
   task automatic wait_xfer(input logic ch, input logic [15:0] src, input logic [15:0] dst);
      int i;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         #1;
         if (xfer_valid === 1'b1) break;
      end
      if (i == 20) begin
         n_errors++;
         conclude();
      end else begin
         chk("xfer_chan", {15'h0, xfer_chan}, {15'h0, ch});
         chk("xfer_src", xfer_src, src);
         chk("xfer_dst", xfer_dst, dst);
      end
   endtask : wait_xfer

   // Main sequence.
   initial begin
      rst_n = 1'b0;
      {addr, wdata, wr, rd, fire, line, hold} = '0;
      n_errors = 0;
      checked = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(ra(0, OFF_CTRL), 16'h0000);
      wr_reg(ra(0, OFF_SRC_RL), 16'h0100);
      wr_reg(ra(0, OFF_DST_RL), 16'h0200);
      wr_reg(ra(0, OFF_CNT_RL), 16'h0002);
      wr_reg(ra(0, OFF_CTRL), 16'h0008);
      rd_chk(ra(0, OFF_CTRL), 16'h0008);
      rd_chk(ra(0, OFF_FWD_PTR), 16'h0100);
      rd_chk(ra(0, OFF_COUNT), 16'h0002);
      // A read-only place ignores writes and an unmapped one reads zero.
      wr_reg(ra(0, OFF_FWD_PTR), 16'h5555);
      rd_chk(ra(0, OFF_FWD_PTR), 16'h0100);
      rd_chk(5'h1F, 16'h0000);
      // Active channel serves each request at once; flag reads zero after.
      req(3'h0, 1'b0);
      wait_xfer(1'b0, 16'h0100, 16'h0200);
      rd_chk(ra(0, OFF_CTRL), 16'h0008);
      rd_chk(ra(0, OFF_FWD_PTR), 16'h0101);
      rd_chk(ra(0, OFF_COUNT), 16'h0001);
      // Interrupt enabled ahead of the last transfer, so it rises with the status bit.
      wr_reg(IRQ_ENABLE, 16'h0001);
      req(3'h0, 1'b0);
      wait_xfer(1'b0, 16'h0101, 16'h0200);
      chk("irq", {15'h0, irq}, 16'h0001);
      rd_chk(ra(0, OFF_CTRL), 16'h0000);
      rd_chk(IRQ_STATUS, 16'h0001);
      // Interrupt raised, masked, then cleared.
      wr_reg(IRQ_ENABLE, 16'h0001);
      idle(2);
      chk("irq", {15'h0, irq}, 16'h0001);
      wr_reg(IRQ_ENABLE, 16'h0000);
      idle(2);
      chk("irq", {15'h0, irq}, 16'h0000);
      wr_reg(IRQ_ENABLE, 16'h0001);
      wr_reg(IRQ_CLEAR, 16'h0001);
      idle(2);
      chk("irq", {15'h0, irq}, 16'h0000);
      rd_chk(IRQ_STATUS, 16'h0000);
      // A request on an inactive channel stays pending.
      req(3'h0, 1'b0);
      idle(4);
      rd_chk(ra(0, OFF_CTRL), 16'h0010);
      idle(10);
      wr_reg(ra(0, OFF_CTRL), 16'h0010);
      rd_chk(ra(0, OFF_CTRL), 16'h0010);
      // Re-enabling restarts from the reload values and serves the pending request.
      wr_reg(ra(0, OFF_CNT_RL), 16'h0003);
      wr_reg(ra(0, OFF_CTRL), 16'h0018);
      wait_xfer(1'b0, 16'h0100, 16'h0200);
      rd_chk(ra(0, OFF_COUNT), 16'h0002);
      rd_chk(ra(0, OFF_FWD_PTR), 16'h0101);
      // Software clears the flag with zero and cannot set it with one.
      wr_reg(ra(0, OFF_CTRL), 16'h0000);
      req(3'h0, 1'b0);
      idle(4);
      rd_chk(ra(0, OFF_CTRL), 16'h0010);
      wr_reg(ra(0, OFF_CTRL), 16'h0000);
      rd_chk(ra(0, OFF_CTRL), 16'h0000);
      wr_reg(ra(0, OFF_CTRL), 16'h0010);
      rd_chk(ra(0, OFF_CTRL), 16'h0000);
      // Channel one with the destination stepping, on request line one.
      wr_reg(ra(1, OFF_SRC_RL), 16'h0300);
      wr_reg(ra(1, OFF_DST_RL), 16'h0400);
      wr_reg(ra(1, OFF_CNT_RL), 16'h0005);
      wr_reg(ra(1, OFF_CTRL), 16'h0029);
      rd_chk(ra(1, OFF_FWD_PTR), 16'h0400);
      req(3'h1, 1'b0);
      wait_xfer(1'b1, 16'h0300, 16'h0400);
      rd_chk(ra(1, OFF_FWD_PTR), 16'h0401);
      // A new source selection may set the flag; software then clears it.
      wr_reg(ra(1, OFF_CTRL), 16'h0020);
      req(3'h2, 1'b1);
      wr_reg(ra(1, OFF_CTRL), 16'h0040);
      rd_chk(ra(1, OFF_CTRL), 16'h0050);
      wr_reg(ra(1, OFF_CTRL), 16'h0040);
      rd_chk(ra(1, OFF_CTRL), 16'h0040);
      conclude();
   end
endmodule : tb_top
